// >>> hdl/coprocessor_vci_initiator.sv
// Purpose: bus initiator toward a basic VCI target for the coprocessor
// Assumes: target answers cmdval with cmdack handshake; single clock
// Notes: no error handling on the bus by design
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module coprocessor_vci_initiator
    import link_pkg::*;
(
    input wire logic sys_clk, // 100 MHz clock
    input wire logic arst_n, // async reset, active low
    input wire logic [ADDR_W-1:0] reg_addr, // register index
    input wire logic [DATA_W-1:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [DATA_W-1:0] reg_rdata, // read data, next cycle
    output logic cpu_stall, // hold cpu while waiting
    input wire logic vec_load, // vector load into store
    input wire logic [DATA_W*FIFO_DEPTH-1:0] vec_in, // vector words in
    output logic [DATA_W*FIFO_DEPTH-1:0] vec_out, // vector words out
    output logic cmdval, // command valid
    input wire logic cmdack, // command accepted
    output logic [1:0] cmd, // read or write
    output logic [TA_W-1:0] address, // target address
    output logic [1:0] be, // byte enables
    output logic [DATA_W-1:0] wdata, // write word
    output logic eop, // last cell of message
    input wire logic rspval, // response valid
    output logic rspack, // response accepted
    input wire logic [DATA_W-1:0] rdata, // response word
    output logic [1:0] endpoint_sel // endpoint index field
);
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_CMD = 5'b00010,
        ST_RSP = 5'b00100,
        ST_DRAIN = 5'b01000,
        ST_FILL = 5'b10000
    } state_type;

    logic rst_meta, rst_n;
    state_type state_reg;
    logic en_reg, burst_reg, byte_reg;
    logic [CNT_W-1:0] np_reg;
    logic [1:0] ep_reg;
    logic [TA_W-1:0] target_reg;
    logic last_reg, busy_reg, wr_msg_reg;
    logic [PTR_W:0] count_reg; // words held in store
    logic [PTR_W-1:0] rd_ptr_reg, bus_ptr_reg;
    logic [PKT_W-1:0] pkt_reg;
    logic [DATA_W*FIFO_DEPTH-1:0] store_data;
    logic [DATA_W-1:0] hold_reg; // normal read result
    logic rd_pend_reg, hold_valid_reg, sent_reg; // stalled read, answer held, cell out
    logic st_wr, fifo_hit_wr, fifo_hit_rd, store_empty, store_full;
    logic [PTR_W-1:0] st_idx;
    logic [DATA_W-1:0] st_data;
    logic [PKT_W-1:0] pkt_total;

    // reset release through two flops
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    assign fifo_hit_wr = reg_wr && reg_addr == IDX_FIFO && en_reg;
    assign fifo_hit_rd = reg_rd && reg_addr == IDX_FIFO && en_reg;
    assign store_empty = count_reg == '0;
    assign store_full = count_reg == (PTR_W+1)'(FIFO_DEPTH);
    assign pkt_total = PKT_W'({np_reg, 1'b0}) + PKT_W'(2);

    // control register; fields other than enable and endpoint frozen while on
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            en_reg <= CONTROL_RESET[CTL_EN_BIT];
            burst_reg <= CONTROL_RESET[CTL_BURST_BIT];
            byte_reg <= CONTROL_RESET[CTL_BYTE_BIT];
            np_reg <= CONTROL_RESET[CTL_NP_LSB +: CNT_W];
            ep_reg <= CONTROL_RESET[CTL_EP_LSB +: 2];
        end else if (reg_wr && reg_addr == IDX_CONTROL) begin
            en_reg <= reg_wdata[CTL_EN_BIT];
            ep_reg <= reg_wdata[CTL_EP_LSB +: 2];
            if (!en_reg) begin
                burst_reg <= reg_wdata[CTL_BURST_BIT];
                byte_reg <= reg_wdata[CTL_BYTE_BIT];
                np_reg <= reg_wdata[CTL_NP_LSB +: CNT_W];
            end
        end
    end

    // target address, written only when no transfer active
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            target_reg <= '0;
        end else if (reg_wr && reg_addr == IDX_TARGET && !busy_reg) begin
            target_reg <= reg_wdata[TA_W-1:0];
        end
    end

    // last word flag: set wins over write-one clear
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            last_reg <= 1'b0;
        end else if (burst_reg && !wr_msg_reg && fifo_hit_rd && !cpu_stall &&
                     rd_ptr_reg == PTR_LAST && pkt_reg == pkt_total) begin
            last_reg <= 1'b1;
        end else if (reg_wr && reg_addr == IDX_STATUS && reg_wdata[ST_LAST_BIT]) begin
            last_reg <= 1'b0;
        end
    end

    // store write port: cpu words or bus answers
    always_comb begin
        st_wr = 1'b0;
        st_idx = count_reg[PTR_W-1:0];
        st_data = reg_wdata;
        if (rspval && ((state_reg == ST_RSP && rd_pend_reg) ||
                       (state_reg == ST_FILL && sent_reg))) begin
            st_wr = 1'b1;
            st_idx = bus_ptr_reg;
            st_data = rdata;
        end else if (fifo_hit_wr && (burst_reg ? !store_full : store_empty)) begin
            st_wr = 1'b1;
        end
    end

    word_store u_store (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .wr_en(st_wr),
        .wr_idx(st_idx),
        .wr_data(st_data),
        .vec_en(vec_load && en_reg && store_empty),
        .vec_data(vec_in),
        .all_data(store_data)
    );
    assign vec_out = store_data;

    // stall: normal read waiting, or burst read with store not refilled
    assign cpu_stall = (rd_pend_reg && state_reg != ST_IDLE) ||
                       (fifo_hit_rd && burst_reg && store_empty);

    // sequencer; the block only ever issues commands
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            count_reg <= '0;
            rd_ptr_reg <= '0;
            bus_ptr_reg <= '0;
            pkt_reg <= '0;
            busy_reg <= 1'b0;
            wr_msg_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            hold_reg <= '0;
            hold_valid_reg <= 1'b0;
            sent_reg <= 1'b0;
        end else if (!en_reg) begin
            state_reg <= ST_IDLE; // disabling cuts any message
            count_reg <= '0;
            rd_ptr_reg <= '0;
            pkt_reg <= '0;
            busy_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            hold_valid_reg <= 1'b0;
            sent_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    if (st_wr) begin
                        count_reg <= count_reg + (PTR_W+1)'(1);
                        wr_msg_reg <= 1'b1;
                        busy_reg <= 1'b1;
                        if (!burst_reg) begin
                            state_reg <= ST_CMD;
                            bus_ptr_reg <= '0;
                        end else if (count_reg == (PTR_W+1)'(FIFO_DEPTH - 1)) begin
                            state_reg <= ST_DRAIN;
                            bus_ptr_reg <= '0;
                        end
                    end else if (fifo_hit_rd) begin
                        if (!burst_reg && hold_valid_reg) begin
                            hold_valid_reg <= 1'b0; // reissued read takes the answer
                        end else if (!burst_reg) begin
                            rd_pend_reg <= 1'b1;
                            wr_msg_reg <= 1'b0;
                            busy_reg <= 1'b1;
                            bus_ptr_reg <= '0;
                            state_reg <= ST_CMD;
                        end else if (store_empty && pkt_reg != pkt_total) begin
                            wr_msg_reg <= 1'b0;
                            busy_reg <= 1'b1;
                            rd_pend_reg <= 1'b1;
                            bus_ptr_reg <= '0;
                            state_reg <= ST_FILL;
                        end else if (!store_empty) begin
                            rd_ptr_reg <= rd_ptr_reg + PTR_W'(1);
                            count_reg <= count_reg - (PTR_W+1)'(1);
                        end
                    end
                end
                ST_CMD: begin
                    if (cmdack) begin
                        state_reg <= ST_RSP;
                    end
                end
                ST_RSP: begin
                    if (rspval) begin
                        state_reg <= ST_IDLE;
                        busy_reg <= 1'b0;
                        count_reg <= '0;
                        if (rd_pend_reg) begin
                            hold_reg <= rdata;
                            rd_pend_reg <= 1'b0;
                            hold_valid_reg <= 1'b1;
                        end
                    end
                end
                ST_DRAIN, ST_FILL: begin
                    if (!sent_reg && cmdack) begin
                        sent_reg <= 1'b1; // cell taken, await its answer
                    end else if (sent_reg && rspval) begin
                        sent_reg <= 1'b0;
                        bus_ptr_reg <= bus_ptr_reg + PTR_W'(1);
                        if (bus_ptr_reg == PTR_LAST) begin
                            state_reg <= ST_IDLE;
                            rd_pend_reg <= 1'b0;
                            if (state_reg == ST_FILL) begin
                                count_reg <= (PTR_W+1)'(FIFO_DEPTH);
                                rd_ptr_reg <= '0;
                                pkt_reg <= pkt_pkt_next(pkt_reg);
                                busy_reg <= pkt_reg + PKT_W'(1) != pkt_total;
                            end else begin
                                count_reg <= '0;
                                busy_reg <= 1'b0;
                            end
                        end
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    function automatic logic [PKT_W-1:0] pkt_pkt_next(input logic [PKT_W-1:0] p);
        pkt_pkt_next = p + PKT_W'(1);
    endfunction

    // bus command side
    // one cell in flight: command until taken, then wait for its answer
    assign cmdval = state_reg == ST_CMD ||
                    ((state_reg == ST_DRAIN || state_reg == ST_FILL) && !sent_reg);
    assign cmd = wr_msg_reg ? CMD_WRITE : CMD_READ;
    assign address = target_reg;
    assign be = byte_reg ? BE_BYTE : BE_WORD;
    assign wdata = store_data[bus_ptr_reg*DATA_W +: DATA_W];
    assign eop = state_reg == ST_CMD || bus_ptr_reg == PTR_LAST;
    assign rspack = state_reg == ST_RSP ||
                    ((state_reg == ST_DRAIN || state_reg == ST_FILL) && sent_reg);
    assign endpoint_sel = ep_reg;

    // read data, one cycle after the strobe
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                IDX_CONTROL: reg_rdata <= {6'h00, ep_reg, np_reg, 1'b0, byte_reg,
                                           burst_reg, en_reg};
                IDX_STATUS: reg_rdata <= {12'h000, last_reg, busy_reg,
                                          store_full, store_empty};
                IDX_TARGET: reg_rdata <= {10'h000, target_reg};
                IDX_FIFO: reg_rdata <= burst_reg ?
                          store_data[rd_ptr_reg*DATA_W +: DATA_W] : hold_reg;
                default: reg_rdata <= '0;
            endcase
        end
    end

    AST_ADDR: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cmdval |-> address == target_reg) else $error("address not target");
    AST_BE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        be == (byte_reg ? 2'b01 : 2'b11)) else $error("bad byte enable");
    AST_CFG: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $past(en_reg) && en_reg |-> $stable(np_reg)) else $error("config changed");
    AST_BUSY: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cmdval |-> busy_reg) else $error("command without busy");
    AST_LAST: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(last_reg) |-> $past(reg_wr)) else $error("last flag lost");
    AST_DRAIN: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(state_reg == ST_DRAIN) |-> store_full) else $error("drain not full");
    AST_IDLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !en_reg |=> state_reg == ST_IDLE) else $error("active while off");
    AST_STALL: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_reg == ST_CMD && rd_pend_reg |-> cpu_stall) else $error("no stall");

    // cell handshake halves and a normal read request
    sequence seq_cell_taken;
        cmdval && cmdack;
    endsequence
    sequence seq_cell_answered;
        rspval && rspack;
    endsequence
    sequence seq_normal_read;
        state_reg == ST_IDLE && fifo_hit_rd && !burst_reg && !hold_valid_reg;
    endsequence
    // a held command would be taken as a new cell by a real target
    AST_ONE_CELL: assert property (@(posedge sys_clk) disable iff (!rst_n)
        seq_cell_taken |=> !cmdval) else $error("command held after accept");
    AST_RD_START: assert property (@(posedge sys_clk) disable iff (!rst_n)
        seq_normal_read |=> state_reg == ST_CMD && cpu_stall) else $error("read not started");
    AST_FILL_STALL: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_reg == ST_FILL |-> cpu_stall) else $error("refill without stall");
    AST_FILL_DONE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (en_reg && state_reg == ST_FILL && bus_ptr_reg == PTR_LAST) ##0 seq_cell_answered
        |=> state_reg == ST_IDLE && store_full) else $error("packet not loaded");
    AST_DRAIN_DONE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (en_reg && state_reg == ST_DRAIN && bus_ptr_reg == PTR_LAST) ##0 seq_cell_answered
        |=> !busy_reg && store_empty) else $error("busy after last answer");
    AST_LAST_SET: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(last_reg) |-> $past(pkt_reg) == $past(pkt_total)) else $error("early last flag");
    AST_ONE_WORD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !burst_reg |-> count_reg <= (PTR_W+1)'(1)) else $error("normal store overfilled");
endmodule // coprocessor_vci_initiator

// >>> hdl/link_pkg.sv
// Purpose: shared constants for the coprocessor bus initiator
// Assumes: 16-bit coprocessor register port, 100 MHz sys_clk
// Notes: register indices are word indices on the plain port
package link_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 3;
    localparam int FIFO_DEPTH = 8;
    localparam int PTR_W = 3;
    localparam int CNT_W = 4;
    localparam int TA_W = 6;
    localparam int PKT_W = 6;
    // register indices
    localparam logic [ADDR_W-1:0] IDX_CONTROL = 3'h0;
    localparam logic [ADDR_W-1:0] IDX_STATUS = 3'h1;
    localparam logic [ADDR_W-1:0] IDX_TARGET = 3'h2;
    localparam logic [ADDR_W-1:0] IDX_FIFO = 3'h3;
    // control fields
    localparam int CTL_EN_BIT = 0;
    localparam int CTL_BURST_BIT = 1;
    localparam int CTL_BYTE_BIT = 2;
    localparam int CTL_NP_LSB = 4;
    localparam int CTL_EP_LSB = 8;
    localparam logic [DATA_W-1:0] CONTROL_RESET = 16'h02f0;
    localparam logic [DATA_W-1:0] STATUS_RESET = 16'h0001;
    // status fields
    localparam int ST_EMPTY_BIT = 0;
    localparam int ST_FULL_BIT = 1;
    localparam int ST_BUSY_BIT = 2;
    localparam int ST_LAST_BIT = 3;
    // byte enables
    localparam logic [1:0] BE_WORD = 2'b11;
    localparam logic [1:0] BE_BYTE = 2'b01;
    localparam logic [1:0] CMD_READ = 2'b01;
    localparam logic [1:0] CMD_WRITE = 2'b10;
    localparam logic [PTR_W-1:0] PTR_LAST = 3'h7;
endpackage

// >>> hdl/word_store.sv
// Purpose: eight-word flip-flop store shared by transmit and receive
// Assumes: one writer port, whole-array read out
// Notes: vector load fills all entries in one cycle
`timescale 1ns/1ps
module word_store
    import link_pkg::*;
(
    input wire logic sys_clk, // clock
    input wire logic rst_n, // synced reset
    input wire logic wr_en, // single word write
    input wire logic [PTR_W-1:0] wr_idx, // word index
    input wire logic [DATA_W-1:0] wr_data, // word
    input wire logic vec_en, // whole store write
    input wire logic [DATA_W*FIFO_DEPTH-1:0] vec_data, // all words
    output logic [DATA_W*FIFO_DEPTH-1:0] all_data // all words
);
    // one entry per word; vector write takes priority
    for (genvar i = 0; i < FIFO_DEPTH; i++) begin : g_word
        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                all_data[i*DATA_W +: DATA_W] <= '0;
            end else if (vec_en) begin
                all_data[i*DATA_W +: DATA_W] <= vec_data[i*DATA_W +: DATA_W];
            end else if (wr_en && wr_idx == PTR_W'(i)) begin
                all_data[i*DATA_W +: DATA_W] <= wr_data;
            end
        end
    end
endmodule // word_store

// >>> testbench/vci_target_model.sv
// Purpose: behavioural bus target answering the initiator cell by cell
// Assumes: one cell in flight; every accepted cell gets one response
// Notes: slow adds wait states; idle rdata toggles so stale use shows
`timescale 1ns/1ps
module vci_target_model
    import link_pkg::*;
(
    input wire logic sys_clk, // clock
    input wire logic rst_n, // reset, active low
    input wire logic slow, // add wait states
    input wire logic cmdval, // command valid
    output logic cmdack, // command accepted
    input wire logic [1:0] cmd, // read or write
    input wire logic [TA_W-1:0] address, // target address
    input wire logic [1:0] be, // byte enables
    input wire logic [DATA_W-1:0] wdata, // write word
    input wire logic eop, // last cell of message
    output logic rspval, // response valid
    input wire logic rspack, // response accepted
    output logic [DATA_W-1:0] rdata // response word
);
    int rd_cnt, wr_cnt;
    logic pend;
    logic [2:0] wait_cnt, dly;
    logic [1:0] last_cmd, last_be;
    logic last_eop;
    logic [TA_W-1:0] last_addr;
    logic [DATA_W-1:0] last_wdata, rsp_word;
    logic [DATA_W-1:0] wr_log [0:31];
    assign dly = slow ? 3'h3 : 3'h0;
    // only ever answers a command; response carries no error field
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmdack <= 1'b0;
            rspval <= 1'b0;
            pend <= 1'b0;
            wait_cnt <= 3'h0;
            rd_cnt <= 0;
            wr_cnt <= 0;
            rdata <= 16'hffff;
        end else if (!pend) begin
            rdata <= ~rdata;
            if (cmdack && cmdval) begin
                cmdack <= 1'b0;
                pend <= 1'b1;
                wait_cnt <= 3'h0;
                last_cmd <= cmd;
                last_be <= be;
                last_eop <= eop;
                last_addr <= address;
                last_wdata <= wdata;
                if (cmd == CMD_READ) begin
                    rsp_word <= 16'h5a00 + 16'(rd_cnt);
                    rd_cnt <= rd_cnt + 1;
                end else begin
                    wr_log[wr_cnt[4:0]] <= wdata;
                    wr_cnt <= wr_cnt + 1;
                end
            end else if (cmdval && wait_cnt >= dly) begin
                cmdack <= 1'b1;
            end else if (cmdval) begin
                wait_cnt <= wait_cnt + 3'h1;
            end
        end else if (rspval && rspack) begin
            rspval <= 1'b0;
            pend <= 1'b0;
            rdata <= ~rdata;
        end else if (!rspval && wait_cnt >= dly) begin
            rspval <= 1'b1;
            rdata <= rsp_word;
        end else if (!rspval) begin
            wait_cnt <= wait_cnt + 3'h1;
            rdata <= ~rdata;
        end
    end
endmodule // vci_target_model

// >>> testbench/test_coprocessor_vci_initiator.sv
// Purpose: self-checking bench for the coprocessor bus initiator
// Assumes: target model answers every cell; one clock domain
// Notes: a fifo read that stalls is reissued once the stall drops
`timescale 1ns/1ps
module test_coprocessor_vci_initiator
    import link_pkg::*;
;
    logic sys_clk, arst_n, reg_wr, reg_rd, cpu_stall, vec_load, slow;
    logic cmdval, cmdack, eop, rspval, rspack;
    logic stalled, first_stall, any_stall, saw_busy;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, rdata, wdata;
    logic [DATA_W*FIFO_DEPTH-1:0] vec_in, vec_out;
    logic [1:0] cmd, be, endpoint_sel;
    logic [TA_W-1:0] address;
    int error_cnt, n_compared, cycles, base_wr, base_rd;
    coprocessor_vci_initiator DUT (.sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .cpu_stall, .vec_load, .vec_in, .vec_out, .cmdval, .cmdack,
        .cmd, .address, .be, .wdata, .eop, .rspval, .rspack, .rdata, .endpoint_sel);
    vci_target_model model (.sys_clk, .rst_n(arst_n), .slow, .cmdval, .cmdack, .cmd,
        .address, .be, .wdata, .eop, .rspval, .rspack, .rdata);
    // 100 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    // hang guard, far above the few hundred cycles the tests need
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            wrap_up();
        end
    end
    task check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    // strobe then a quiet edge, so no signal is assigned twice per step
    task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    task rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
        stalled = cpu_stall;
        @(posedge sys_clk);
    endtask
    task fifo_rd(output logic [DATA_W-1:0] d);
        int n;
        rd(IDX_FIFO, d);
        first_stall = stalled;
        if (stalled === 1'b1) begin
            any_stall = 1'b1;
            for (n = 0; n < 200 && cpu_stall !== 1'b0; n++) begin
                @(posedge sys_clk);
                #1;
            end
            @(posedge sys_clk);
            rd(IDX_FIFO, d);
        end
    endtask
    task wait_idle();
        logic [DATA_W-1:0] s;
        int n;
        saw_busy = 1'b0;
        s = 16'hffff;
        for (n = 0; n < 100 && s[ST_BUSY_BIT] !== 1'b0; n++) begin
            rd(IDX_STATUS, s);
            if (s[ST_BUSY_BIT] === 1'b1) begin
                saw_busy = 1'b1;
            end
        end
        check({15'h0000, s[ST_BUSY_BIT]}, 16'h0000);
    endtask
    task wrap_up();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // main sequence
    initial begin : main
        logic [DATA_W-1:0] v;
        int i;
        error_cnt = 0;
        n_compared = 0;
        any_stall = 1'b0;
        arst_n = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        vec_load = 1'b0;
        vec_in = '0;
        slow = 1'b1;
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rd(IDX_CONTROL, v);
        check(v, CONTROL_RESET);
        rd(IDX_STATUS, v);
        check(v, STATUS_RESET);
        rd(IDX_TARGET, v);
        check(v, 16'h0000);
        check({14'h0000, endpoint_sel}, 16'h0002);
        $display("test reset done");
        // config taken while off, frozen once on; stray index harmless
        wr(IDX_CONTROL, 16'h0134);
        wr(3'h6, 16'hffff);
        wr(IDX_TARGET, 16'h002a);
        rd(IDX_CONTROL, v);
        check(v, 16'h0134);
        check({14'h0000, endpoint_sel}, 16'h0001);
        wr(IDX_CONTROL, 16'h0135);
        wr(IDX_CONTROL, 16'h01f3);
        rd(IDX_CONTROL, v);
        check(v, 16'h0135);
        rd(IDX_TARGET, v);
        check(v, 16'h002a);
        check(16'(model.wr_cnt + model.rd_cnt), 16'h0000);
        $display("test config done");
        // normal writes in byte then word width
        for (i = 0; i < 2; i++) begin
            if (i == 1) begin
                wr(IDX_CONTROL, 16'h0000);
                wr(IDX_CONTROL, 16'h0001);
            end
            base_wr = model.wr_cnt;
            wr(IDX_FIFO, 16'(16'h1234 + i));
            wait_idle();
            check({15'h0000, saw_busy}, 16'h0001);
            check(16'(model.wr_cnt - base_wr), 16'h0001);
            check(model.last_wdata, 16'(16'h1234 + i));
            check({10'h000, model.last_addr}, 16'h002a);
            check({14'h0000, model.last_cmd}, {14'h0000, CMD_WRITE});
            check({15'h0000, model.last_eop}, 16'h0001);
            check({14'h0000, model.last_be}, {14'h0000, i == 0 ? BE_BYTE : BE_WORD});
        end
        $display("test normal write done");
        // normal read stalls until the answer, then hands the word over
        base_rd = model.rd_cnt;
        fifo_rd(v);
        check({15'h0000, first_stall}, 16'h0001);
        check(v, 16'(16'h5a00 + base_rd));
        check(16'(model.rd_cnt - base_rd), 16'h0001);
        $display("test normal read done");
        // burst write: nothing leaves before the eighth word
        wr(IDX_CONTROL, 16'h0002);
        wr(IDX_CONTROL, 16'h0003);
        base_wr = model.wr_cnt;
        for (i = 0; i < 8; i++) begin
            wr(IDX_FIFO, 16'(16'hc000 + i));
            if (i == 0) begin
                rd(IDX_STATUS, v);
                check({15'h0000, v[ST_BUSY_BIT]}, 16'h0001);
            end
            if (i == 6) begin
                check(16'(model.wr_cnt - base_wr), 16'h0000);
            end
        end
        wait_idle();
        for (i = 0; i < 8; i++) begin
            check(model.wr_log[5'(base_wr + i)], 16'(16'hc000 + i));
        end
        rd(IDX_STATUS, v);
        check({15'h0000, v[ST_EMPTY_BIT]}, 16'h0001);
        check({15'h0000, model.last_eop}, 16'h0001);
        $display("test burst write done");
        // burst read of two packets with a slow target
        wr(IDX_CONTROL, 16'h0000);
        wr(IDX_CONTROL, 16'h0002);
        wr(IDX_CONTROL, 16'h0003);
        base_rd = model.rd_cnt;
        for (i = 0; i < 16; i++) begin
            if (i == 15) begin
                rd(IDX_STATUS, v);
                check({15'h0000, v[ST_LAST_BIT]}, 16'h0000);
            end
            fifo_rd(v);
            check(v, 16'(16'h5a00 + base_rd + i));
        end
        check({15'h0000, any_stall}, 16'h0001);
        rd(IDX_STATUS, v);
        check({15'h0000, v[ST_LAST_BIT]}, 16'h0001);
        repeat (20) @(posedge sys_clk);
        check(16'(model.rd_cnt - base_rd), 16'h0010);
        wr(IDX_STATUS, 16'h0000);
        rd(IDX_STATUS, v);
        check({15'h0000, v[ST_LAST_BIT]}, 16'h0001);
        wr(IDX_STATUS, 16'h0008);
        rd(IDX_STATUS, v);
        check({15'h0000, v[ST_LAST_BIT]}, 16'h0000);
        $display("test burst read done");
        // vector load fills the whole store in one cycle
        for (i = 0; i < FIFO_DEPTH; i++) begin
            vec_in[i*DATA_W +: DATA_W] <= 16'(16'h7e00 + i);
        end
        vec_load <= 1'b1;
        @(posedge sys_clk);
        vec_load <= 1'b0;
        @(posedge sys_clk);
        #1;
        for (i = 0; i < FIFO_DEPTH; i++) begin
            check(vec_out[i*DATA_W +: DATA_W], 16'(16'h7e00 + i));
        end
        $display("test vector load done");
        wrap_up();
    end
endmodule // test_coprocessor_vci_initiator
